// file: frame_builder_map.svh
`ifndef FRAME_BUILDER_MAP_SVH
`define FRAME_BUILDER_MAP_SVH
// ****************************************
// Framing layer
// ****************************************
`define START_BYTE     8'h7E
`define CK_BASE        8'hFF
`define TYPE_REMOTE    8'h87
`define TYPE_LOCAL     8'h88
`define TYPE_TX_STATUS 8'h89
// ****************************************
// Body offsets, counted from the type byte
// ****************************************
`define REM_ADDR_OFS   5'd2
`define REM_IP_OFS     5'd6
`define REM_CMD_OFS    5'd10
`define REM_STAT_OFS   5'd12
`define REM_HDR_LEN    5'd13
`define LOC_CMD_OFS    5'd2
`define LOC_STAT_OFS   5'd4
`define LOC_HDR_LEN    5'd5
`define TXS_STAT_OFS   5'd2
`define TXS_LEN        5'd3
`define PARAM_MAX      4'd8
`define BODY_MAX       21
// ****************************************
// Delivery codes of the status frame
// ****************************************
`define DLV_SUCCESS    8'h00
`define DLV_STACK_DOWN 8'h03
`define DLV_PHY_FAULT  8'h04
`define DLV_ACK_TMO    8'h21
`define DLV_NO_RES     8'h32
`define DLV_TOO_LONG   8'h74
`define DLV_SOCK_FAIL  8'h76
`define DLV_NO_CONN    8'h77
`define DLV_PORT_MISS  8'h78
`endif

// file: frame_builder_pkg.sv
`default_nettype none
package frame_builder_pkg;
   // Command outcome, numeric order is the wire code except cs_tx_fail in local frames
   typedef enum logic [2:0] {
      cs_ok, cs_error, cs_bad_cmd, cs_bad_param, cs_tx_fail
   } cmd_status_type;
   // Transmit attempt outcome
   typedef enum logic [3:0] {
      tc_success, tc_stack_down, tc_phy_fault, tc_ack_timeout,
      tc_no_resource, tc_too_long, tc_socket_fail, tc_no_connection,
      tc_port_mismatch
   } tx_cause_type;
   typedef struct packed {
      logic [7:0]     frame_id;
      logic [31:0]    ipv4;
      logic [15:0]    cmd;
      cmd_status_type status;
      logic           query;
      logic [3:0]     plen;
      logic [63:0]    param;
   } remote_req_type;
   typedef struct packed {
      logic [7:0]     frame_id;
      logic [15:0]    cmd;
      cmd_status_type status;
      logic           read;
      logic [3:0]     plen;
      logic [63:0]    param;
   } local_req_type;
   typedef struct packed {
      logic [7:0]   frame_id;
      tx_cause_type cause;
   } txs_req_type;
endpackage
`default_nettype wire

// file: host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Host side serial receiver
// ****************************************
module host_model (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // Byte stream from the framer
   input  wire logic       ser_valid,
   output logic            ser_ready,
   input  wire logic [7:0] ser_data,
   // Pacing
   input  wire logic       slow
);
   logic [7:0] rx_q[$];
   logic [1:0] pace_q = 2'h0;
   // Slow host takes one byte in four so the FIFO backs up
   always @(negedge ref_clk) begin
      pace_q    <= pace_q + 2'h1;
      ser_ready <= !slow || (pace_q == 2'h3);
   end
   // Keep accepted bytes in arrival order for the bench
   always @(posedge ref_clk) begin
      if (!rst && ser_valid && ser_ready) begin
         rx_q.push_back(ser_data);
      end
   end
endmodule // host_model
`default_nettype wire

// file: response_framer.sv
`timescale 1ns/100ps
`default_nettype none
`include "frame_builder_map.svh"
// Functional notes
// - Remote reply triggers a frame of type 0x87.
// - Remote frame address offsets 5-12: four zero bytes, then IPv4.
// - Remote frame command characters at offsets 13 and 14.
// - Remote frame status at offset 15, codes 0 to 4.
// - Parameter bytes follow remote status only for a query.
// - Every local command gets a 0x88 frame; scans send several.
// - Local frame: id, command at 5-6, status codes 0 to 3.
// - Local frame carries parameter bytes on read, none on write.
// - Each transmit attempt is reported in a 0x89 frame.
// - Status frame echoes frame id; id zero suppresses the frame.
// - Delivery codes 0x00, 0x03 and 0x04.
// - Delivery code 0x21 on acknowledgment timeout.
// - Delivery codes 0x32, 0x74 and 0x76.
// - Delivery codes 0x77 and 0x78.

// ****************************************
// Output byte buffer
// ****************************************
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // Filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             wr_en;
   logic             rd_en;
   // Full and empty straight from the occupancy count
   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign wr_en     = in_valid && in_ready;
   assign rd_en     = out_valid && out_ready;
   assign out_data  = mem[rd_q];
   // Storage, no reset needed on data
   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem[wr_q] <= in_data;
      end
   end
   // Pointers and count
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (wr_en) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (rd_en) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(wr_en) - (AW+1)'(rd_en);
      end
   end
endmodule // byte_fifo

// ****************************************
// Response frame builder
// ****************************************
module response_framer (
   // Clock and reset
   input  wire logic                           ref_clk,
   input  wire logic                           rst,
   // Remote command reply
   input  wire logic                           rem_valid,
   output logic                                rem_ready,
   input  wire frame_builder_pkg::remote_req_type rem_req,
   // Local command reply
   input  wire logic                           loc_valid,
   output logic                                loc_ready,
   input  wire frame_builder_pkg::local_req_type  loc_req,
   // Transmit attempt outcome
   input  wire logic                           txs_valid,
   output logic                                txs_ready,
   input  wire frame_builder_pkg::txs_req_type    txs_req,
   // Serial byte stream to the host
   output logic                                ser_valid,
   input  wire logic                           ser_ready,
   output logic                       [7:0]    ser_data,
   output logic                                busy
);
   import frame_builder_pkg::*;
   typedef enum logic [0:0] {st_idle, st_send} state_type;
   state_type  state_q;
   logic [7:0] body_q [`BODY_MAX];
   logic [7:0] body_d [`BODY_MAX];
   logic [4:0] len_q;
   logic [4:0] len_d;
   logic [4:0] pos_q;
   logic [7:0] sum_q;
   logic [7:0] push_byte;
   logic       push_ready;
   logic       advance;
   logic       emit_d;
   logic       take;
   logic       last;
   // Map command outcome; local frames have no transmit failure
   function automatic logic [7:0] status_code(cmd_status_type s,
                                               logic is_local);
      if (is_local && s == cs_tx_fail) begin
         return 8'h01;
      end
      return {5'h00, s};
   endfunction

   // Map transmit outcome to delivery code
   function automatic logic [7:0] delivery_code(tx_cause_type c);
      case (c)
         tc_success:       return `DLV_SUCCESS;
         tc_stack_down:    return `DLV_STACK_DOWN;
         tc_phy_fault:     return `DLV_PHY_FAULT;
         tc_ack_timeout:   return `DLV_ACK_TMO;
         tc_no_resource:   return `DLV_NO_RES;
         tc_too_long:      return `DLV_TOO_LONG;
         tc_socket_fail:   return `DLV_SOCK_FAIL;
         tc_no_connection: return `DLV_NO_CONN;
         tc_port_mismatch: return `DLV_PORT_MISS;
         default:          return `DLV_PHY_FAULT;
      endcase
   endfunction

   // Longer values are cut so a frame never overruns the body store
   function automatic logic [3:0] clamp_len(logic [3:0] n);
      return (n > `PARAM_MAX) ? `PARAM_MAX : n;
   endfunction

   // Byte i of a right-aligned value, most significant first
   function automatic logic [7:0] param_byte(logic [63:0] v,
                                              logic [3:0] n,
                                              logic [3:0] i);
      logic [3:0] sh;
      sh = n - 4'd1 - i;
      return v[{sh[2:0], 3'b000} +: 8];
   endfunction

   // One request taken at a time, remote first, then local
   assign rem_ready = (state_q == st_idle);
   assign loc_ready = (state_q == st_idle) && !rem_valid;
   assign txs_ready = (state_q == st_idle) && !rem_valid && !loc_valid;
   assign take      = (rem_valid && rem_ready) || (loc_valid && loc_ready)
                      || (txs_valid && txs_ready);
   assign busy      = (state_q == st_send);

   // Assemble the body of the selected frame
   always_comb begin
      logic [3:0] n;
      n = '0;
      body_d = '{default: 8'h00};
      len_d  = '0;
      emit_d = 1'b0;
      if (rem_valid) begin
         n = rem_req.query ? clamp_len(rem_req.plen) : 4'd0;
         body_d[0] = `TYPE_REMOTE;
         body_d[1] = rem_req.frame_id;
         for (int k = 0; k < 4; k++) begin
            body_d[`REM_IP_OFS + k] = rem_req.ipv4[(3-k)*8 +: 8];
         end
         body_d[`REM_CMD_OFS]    = rem_req.cmd[15:8];
         body_d[`REM_CMD_OFS+1]  = rem_req.cmd[7:0];
         body_d[`REM_STAT_OFS]   = status_code(rem_req.status, 1'b0);
         for (int k = 0; k < 8; k++) begin
            if (4'(k) < n) begin
               body_d[`REM_HDR_LEN + k] =
                  param_byte(rem_req.param, n, 4'(k));
            end
         end
         len_d  = `REM_HDR_LEN + 5'(n);
         emit_d = 1'b1;
      end else if (loc_valid) begin
         n = loc_req.read ? clamp_len(loc_req.plen) : 4'd0;
         body_d[0] = `TYPE_LOCAL;
         body_d[1] = loc_req.frame_id;
         body_d[`LOC_CMD_OFS]   = loc_req.cmd[15:8];
         body_d[`LOC_CMD_OFS+1] = loc_req.cmd[7:0];
         body_d[`LOC_STAT_OFS]  = status_code(loc_req.status, 1'b1);
         for (int k = 0; k < 8; k++) begin
            if (4'(k) < n) begin
               body_d[`LOC_HDR_LEN + k] =
                  param_byte(loc_req.param, n, 4'(k));
            end
         end
         len_d  = `LOC_HDR_LEN + 5'(n);
         emit_d = 1'b1;
      end else if (txs_valid) begin
         body_d[0] = `TYPE_TX_STATUS;
         body_d[1] = txs_req.frame_id;
         body_d[`TXS_STAT_OFS] = delivery_code(txs_req.cause);
         len_d  = `TXS_LEN;
         emit_d = (txs_req.frame_id != 8'h00);
      end
   end

   // Body store loaded once per taken request
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         body_q <= '{default: 8'h00};
         len_q <= '0;
      end else if (take) begin
         body_q <= body_d;
         len_q  <= len_d;
      end
   end

   // Byte stream: start, length, body, checksum
   assign last = (pos_q == len_q + 5'd3);
   always_comb begin
      case (pos_q)
         5'd0:    push_byte = `START_BYTE;
         5'd1:    push_byte = 8'h00;
         5'd2:    push_byte = {3'b000, len_q};
         default: push_byte = last ? `CK_BASE - sum_q
                                   : body_q[5'(pos_q - 5'd3)];
      endcase
   end
   assign advance = (state_q == st_send) && push_ready;

   // Frame sequencer; a full buffer holds the position
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= st_idle;
         pos_q   <= '0;
      end else begin
         case (state_q)
            st_idle: begin
               pos_q <= '0;
               if (take && emit_d) begin
                  state_q <= st_send;
               end
            end
            st_send: begin
               if (advance) begin
                  pos_q <= pos_q + 5'd1;
                  if (last) begin
                     state_q <= st_idle;
                  end
               end
            end
            default: state_q <= st_idle;
         endcase
      end
   end

   // Running sum over the body bytes only
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sum_q <= 8'h00;
      end else if (state_q == st_idle) begin
         sum_q <= 8'h00;
      end else if (advance && pos_q >= 5'd3 && !last) begin
         sum_q <= sum_q + push_byte;
      end
   end

   byte_fifo #(
      .WIDTH (8),
      .DEPTH (4)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_valid  (state_q == st_send),
      .in_ready  (push_ready),
      .in_data   (push_byte),
      .out_valid (ser_valid),
      .out_ready (ser_ready),
      .out_data  (ser_data)
   );

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_rem_take;
      rem_valid && rem_ready;
   endsequence
   sequence s_loc_take;
      loc_valid && loc_ready;
   endsequence
   sequence s_first_push;
      advance && pos_q == 5'd0;
   endsequence
   chk_start_delim: assert property (
      s_first_push |-> push_byte == 8'h7E ##1 pos_q == 5'd1)
      else $error("frame does not open with delimiter");
   chk_length_field: assert property (
      advance && pos_q == 5'd2 |-> push_byte == {3'b000, len_q}
         && $stable(len_q))
      else $error("length byte wrong");
   chk_checksum_sum: assert property (
      advance && last && pos_q > 5'd3 |-> 8'(push_byte + sum_q) == 8'hFF
         ##1 state_q == st_idle)
      else $error("checksum does not close frame");
   chk_remote_layout: assert property (
      s_rem_take |=> body_q[0] == 8'h87 && body_q[2] == 8'h00
         && body_q[5] == 8'h00 && body_q[9] == $past(rem_req.ipv4[7:0])
         && body_q[11] == $past(rem_req.cmd[7:0]))
      else $error("remote frame layout wrong");
   chk_remote_nonquery: assert property (
      s_rem_take and !rem_req.query |=> len_q == 5'd13)
      else $error("non-query remote frame not ended at status");
   chk_local_write: assert property (
      s_loc_take and !loc_req.read |=> len_q == 5'd5
         && body_q[0] == 8'h88)
      else $error("local write frame carries parameter");
   chk_txs_suppress: assert property (
      txs_valid && txs_ready && txs_req.frame_id == 8'h00
         |=> state_q == st_idle ##1 (state_q == st_idle || $past(take)))
      else $error("status frame sent for id zero");
   chk_ack_timeout: assert property (
      txs_valid && txs_ready && txs_req.cause == tc_ack_timeout
         |=> body_q[2] == 8'h21 && body_q[0] == 8'h89)
      else $error("ack timeout code wrong");
   chk_frame_begins: assert property (
      state_q == st_idle && take && emit_d |=> s_first_push [*1]
         or (!push_ready ##[1:40] s_first_push))
      else $error("frame did not start");
endmodule // response_framer
`default_nettype wire

// file: response_framer_bench.sv
`timescale 1ns/100ps
`default_nettype none
module response_framer_bench;
   import frame_builder_pkg::*;
   logic           ref_clk, rst, slow, busy;
   logic           rem_valid, rem_ready, loc_valid, loc_ready;
   logic           txs_valid, txs_ready, ser_valid, ser_ready;
   logic [7:0]     ser_data;
   remote_req_type rem_req;
   local_req_type  loc_req;
   txs_req_type    txs_req;
   logic [7:0]     exp_q[$];
   int             err_count, tests_run;
   // ****************************************
   // Design and host
   // ****************************************
   response_framer u_dut (
      .ref_clk(ref_clk), .rst(rst),
      .rem_valid(rem_valid), .rem_ready(rem_ready), .rem_req(rem_req),
      .loc_valid(loc_valid), .loc_ready(loc_ready), .loc_req(loc_req),
      .txs_valid(txs_valid), .txs_ready(txs_ready), .txs_req(txs_req),
      .ser_valid(ser_valid), .ser_ready(ser_ready), .ser_data(ser_data),
      .busy(busy));
   host_model u_host (
      .ref_clk(ref_clk), .rst(rst), .ser_valid(ser_valid),
      .ser_ready(ser_ready), .ser_data(ser_data), .slow(slow));
   // ****************************************
   // Shared tasks
   // ****************************************
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Wait for the offered request to be taken, then withdraw it
   task automatic take(input int ch);
      int n;
      n = 0;
      #1;
      while (!(ch == 0 ? rem_ready : ch == 1 ? loc_ready : txs_ready)
             && n < 400) begin
         @(negedge ref_clk);
         #1;
         n++;
      end
      if (n >= 400) begin
         err_count++;
         $display("Error request ready expected 1 seen 0");
      end
      @(negedge ref_clk);
      rem_valid = 1'b0;
      loc_valid = 1'b0;
      txs_valid = 1'b0;
      // One idle edge so a following request never rises in this step
      @(negedge ref_clk);
   endtask
   // Wrap a body in delimiter, length and checksum
   task automatic expect_frame(input logic [7:0] body[$]);
      logic [7:0] sum;
      sum = 8'h00;
      exp_q.push_back(8'h7E);
      exp_q.push_back(8'h00);
      exp_q.push_back(8'(body.size()));
      foreach (body[i]) begin
         exp_q.push_back(body[i]);
         sum = sum + body[i];
      end
      exp_q.push_back(8'hFF - sum);
   endtask
   // Compare everything the host got against the expectation
   task automatic check_rx(input string name);
      int n;
      n = 0;
      while (u_host.rx_q.size() < exp_q.size() && n < 4000) begin
         @(negedge ref_clk);
         n++;
      end
      repeat (12) @(negedge ref_clk);
      tests_run++;
      if (u_host.rx_q.size() != exp_q.size()) begin
         err_count++;
         $display("Error %s count expected %0d seen %0d", name,
                  exp_q.size(), u_host.rx_q.size());
      end
      foreach (exp_q[i]) begin
         tests_run++;
         if (i >= u_host.rx_q.size() || u_host.rx_q[i] !== exp_q[i]) begin
            err_count++;
            $display("Error %s byte %0d expected %h seen %h", name, i,
                     exp_q[i],
                     i < u_host.rx_q.size() ? u_host.rx_q[i] : 8'h00);
         end
      end
      exp_q.delete();
      u_host.rx_q.delete();
      $display("Test %s finished", name);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   // Every delivery cause back to back, then a silent id zero
   task automatic test_txs;
      logic [7:0] code[9];
      code = '{8'h00, 8'h03, 8'h04, 8'h21, 8'h32, 8'h74, 8'h76, 8'h77, 8'h78};
      for (int c = 0; c < 9; c++) begin
         txs_req.frame_id = 8'(c + 1);
         txs_req.cause    = tx_cause_type'(c);
         txs_valid        = 1'b1;
         take(2);
         expect_frame('{8'h89, 8'(c + 1), code[c]});
      end
      check_rx("tx status");
      txs_req.frame_id = 8'h00;
      txs_valid        = 1'b1;
      take(2);
      tests_run++;
      if (busy !== 1'b0) begin
         err_count++;
         $display("Error busy on id zero expected 0 seen %b", busy);
      end
      check_rx("id zero");
   endtask
   // Remote replies, every status, query and plain
   task automatic test_rem;
      logic [7:0] b[$];
      int         pl;
      for (int s = 0; s < 6; s++) begin
         pl = (s == 5) ? 8 : s;
         rem_req.frame_id = 8'(s + 1);
         rem_req.ipv4     = 32'hC0A80067;
         rem_req.cmd      = 16'h4431;
         rem_req.status   = cmd_status_type'(s % 5);
         rem_req.query    = s[0];
         rem_req.plen     = 4'(pl);
         rem_req.param    = 64'h1122334455667788;
         rem_valid        = 1'b1;
         take(0);
         b = '{8'h87, 8'(s + 1), 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'hA8,
               8'h00, 8'h67, 8'h44, 8'h31, 8'(s % 5)};
         for (int k = pl - 1; k >= 0 && s[0]; k--) begin
            b.push_back(8'(64'h1122334455667788 >> (8 * k)));
         end
         expect_frame(b);
      end
      check_rx("remote");
   endtask
   // Local replies as a burst to a stalling host
   task automatic test_loc;
      logic [7:0] b[$];
      int         pl;
      slow = 1'b1;
      for (int s = 0; s < 5; s++) begin
         pl = (s == 3) ? 8 : 2 * s;
         loc_req.frame_id = 8'(s + 1);
         loc_req.cmd      = 16'h4244;
         loc_req.status   = cmd_status_type'(s);
         loc_req.read     = s[0];
         loc_req.plen     = 4'(pl);
         loc_req.param    = 64'hA1B2C3D4E5F60718;
         loc_valid        = 1'b1;
         take(1);
         b = '{8'h88, 8'(s + 1), 8'h42, 8'h44, (s == 4) ? 8'h01 : 8'(s)};
         for (int k = pl - 1; k >= 0 && s[0]; k--) begin
            b.push_back(8'(64'hA1B2C3D4E5F60718 >> (8 * k)));
         end
         expect_frame(b);
      end
      check_rx("local");
      slow = 1'b0;
   endtask
   // ****************************************
   // Verdict and main sequence
   // ****************************************
   task automatic final_report;
      $display("Checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Stuck handshake cuts the run short
   initial begin
      #200000;
      err_count++;
      final_report();
   end
   initial begin
      err_count = 0;
      tests_run = 0;
      rst       = 1'b1;
      slow      = 1'b0;
      rem_valid = 1'b0;
      loc_valid = 1'b0;
      txs_valid = 1'b0;
      rem_req   = '0;
      loc_req   = '0;
      txs_req   = '0;
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
      @(negedge ref_clk);
      test_txs();
      test_rem();
      test_loc();
      final_report();
   end
endmodule // response_framer_bench
`default_nettype wire
